//--- hdl/wdc_pkg.sv
// package: constants and types for the watchdog configuration word block
// Contract
// - hardware enable fuse 1 runs watchdog always; 0 defers to software enable bit.
// - asleep, period is clock divided by 2^(sleep field+1), field bits 14..10; code gives field 31 2^30, fields 29 and 30 2^29.
// - running, period is clock divided by 2^(run field+1), field bits 4..0; code gives field 31 2^30, fields 29 and 30 2^29.
// - window size 11/10/01/00 opens 25/37.5/50/75 percent of period.
// - window disable bit 7 at 1 gives non-window mode, 0 windowed.
// - clock select 11 picks low-power RC clock; code 00 is reserved.
// - select 10 uses fast RC if windowed, awake, system clock not RC.
// - select 01 uses peripheral clock if awake and system clock not RC.
// - bits 23..16 of the word are unimplemented and read as ones.
// - every field reads back, programs once, and reads one when erased.
package wdc_pkg;
   // ----------------------------------------------------------------
   // word layout
   // ----------------------------------------------------------------
   localparam int WDC_WORD_W = 24;
   localparam int WDC_EN_BIT = 15;
   localparam int WDC_SLP_HI = 14;
   localparam int WDC_SLP_LO = 10;
   localparam int WDC_WIN_HI = 9;
   localparam int WDC_WIN_LO = 8;
   localparam int WDC_WDIS_BIT = 7;
   localparam int WDC_CSEL_HI = 6;
   localparam int WDC_CSEL_LO = 5;
   localparam int WDC_RUN_HI = 4;
   localparam int WDC_RUN_LO = 0;
   localparam logic [7:0] WDC_UNIMPL_VAL = 8'hFF;
   localparam logic [15:0] WDC_ERASED = 16'hFFFF;
   // register index of the word on the read port
   localparam logic [3:0] WDC_ADDR_WORD = 4'h0;
   localparam logic [3:0] WDC_ADDR_STAT = 4'h1;
   localparam logic [3:0] WDC_ADDR_CNT = 4'h2;
   // status word bit positions
   localparam int WDC_ST_RUN = 0;
   localparam int WDC_ST_WIN = 1;
   localparam int WDC_ST_OPEN = 2;
   localparam int WDC_ST_PROG = 3;
   localparam int WDC_ST_CLK_LO = 4;
   // ----------------------------------------------------------------
   // encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] WDC_CS_LOW_POWER_RC_CLOCK = 2'h3;
   localparam logic [1:0] WDC_CS_FAST = 2'h2;
   localparam logic [1:0] WDC_CS_PER = 2'h1;
   localparam logic [1:0] WDC_WS_25 = 2'h3;
   localparam logic [1:0] WDC_WS_375 = 2'h2;
   localparam logic [1:0] WDC_WS_50 = 2'h1;
   localparam int WDC_CNT_W = 31;
   // period exponent limits: top code gives 2^30, codes 29 and 30 are capped at 2^29
   localparam logic [4:0] WDC_CODE_TOP = 5'h1F;
   localparam int WDC_EXP_TOP = 30;
   localparam int WDC_EXP_CAP = 29;

   typedef enum logic [1:0] {
      WDC_SRC_LP = 2'b00,
      WDC_SRC_FRC = 2'b01,
      WDC_SRC_PER = 2'b10
   } wdc_src_t;

   typedef struct packed {
      logic hw_watchdog_enable;
      logic [4:0] sleep_period_select;
      logic [1:0] window_size_select;
      logic window_disable;
      logic [1:0] watchdog_clock_select;
      logic [4:0] run_period_select;
   } wdc_fuse_t;

   typedef struct packed {
      logic sleeping;
      logic sys_on_rc;
      logic sw_enable;
      logic clear;
   } wdc_ctl_t;
endpackage

//--- hdl/wdc_tick.sv
// module: picks the counting clock source and makes one tick per rising source edge
`timescale 1ns/1ps
module wdc_tick
   import wdc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic lp_in,
   input wire logic frc_in,
   input wire logic per_in,
   input wire logic [1:0] csel,
   input wire logic win_on,
   input wire logic sys_on_rc,
   input wire logic sleeping,
   output logic tick,
   output wdc_src_t src
);
   typedef struct packed {
      logic [2:0] lp_s;
      logic [2:0] frc_s;
      logic [2:0] per_s;
      logic lp_q;
      logic frc_q;
      logic per_q;
      logic tick;
   } wdc_tick_st_t;

   wdc_tick_st_t st_reg, st_next;
   logic lp_ok, frc_ok, per_ok, lp_rise, frc_rise, per_rise;

   // ----------------------------------------------------------------
   // source choice
   // ----------------------------------------------------------------
   always_comb begin
      src = WDC_SRC_LP;
      if (csel == WDC_CS_FAST && win_on && !sys_on_rc && !sleeping) begin
         src = WDC_SRC_FRC;
      end else if (csel == WDC_CS_PER && !sys_on_rc && !sleeping) begin
         src = WDC_SRC_PER;
      end
   end

   // ----------------------------------------------------------------
   // synchronisers and edge detect
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.lp_s = {st_reg.lp_s[1:0], lp_in};
      st_next.frc_s = {st_reg.frc_s[1:0], frc_in};
      st_next.per_s = {st_reg.per_s[1:0], per_in};
      // a change counts once stages two and three agree
      lp_ok = st_reg.lp_s[1] == st_reg.lp_s[2];
      frc_ok = st_reg.frc_s[1] == st_reg.frc_s[2];
      per_ok = st_reg.per_s[1] == st_reg.per_s[2];
      if (lp_ok) st_next.lp_q = st_reg.lp_s[2];
      if (frc_ok) st_next.frc_q = st_reg.frc_s[2];
      if (per_ok) st_next.per_q = st_reg.per_s[2];
      lp_rise = lp_ok && st_reg.lp_s[2] && !st_reg.lp_q;
      frc_rise = frc_ok && st_reg.frc_s[2] && !st_reg.frc_q;
      per_rise = per_ok && st_reg.per_s[2] && !st_reg.per_q;
      unique case (src)
         WDC_SRC_FRC: st_next.tick = frc_rise;
         WDC_SRC_PER: st_next.tick = per_rise;
         default: st_next.tick = lp_rise;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tick = st_reg.tick;
endmodule

//--- hdl/wdc_top.sv
// module: program-once watchdog configuration word and the watchdog it steers
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module wdc_top
   import wdc_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire logic [3:0] ADDR,
   input wire logic [23:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [23:0] RDATA,
   input wire logic SLEEPING,
   input wire logic SYS_ON_RC,
   input wire logic SW_ENABLE,
   input wire logic WDT_CLEAR,
   input wire logic LP_CLK_IN,
   input wire logic FRC_CLK_IN,
   input wire logic PER_CLK_IN,
   output logic WDT_RESET,
   output logic WDT_RUNNING
);
   typedef struct packed {
      wdc_fuse_t fuse;
      logic programmed;
      logic [WDC_CNT_W-1:0] cnt;
      logic [23:0] rdata;
      logic wdt_reset;
   } wdc_st_t;

   // power-up state of the fuse array: erased, unprogrammed
   wdc_st_t st_reg = '{fuse: wdc_fuse_t'(WDC_ERASED), programmed: 1'b0,
      cnt: '0, rdata: '0, wdt_reset: 1'b0};
   wdc_st_t st_next;
   logic [5:0] expo;
   logic tick;
   wdc_src_t src;
   logic run_on, win_on, win_open, expired;
   logic [4:0] code;
   logic [WDC_CNT_W-1:0] period, closed_len;
   wdc_fuse_t wr_fuse;
   logic [23:0] word;

   // ----------------------------------------------------------------
   // tick source
   // ----------------------------------------------------------------
   wdc_tick u_tick (
      .clk(CORE_CLK),
      .rst(SYS_RST),
      .lp_in(LP_CLK_IN),
      .frc_in(FRC_CLK_IN),
      .per_in(PER_CLK_IN),
      .csel(st_reg.fuse.watchdog_clock_select),
      .win_on(win_on),
      .sys_on_rc(SYS_ON_RC),
      .sleeping(SLEEPING),
      .tick(tick),
      .src(src)
   );

   // ----------------------------------------------------------------
   // decoded configuration
   // ----------------------------------------------------------------
   always_comb begin
      run_on = st_reg.fuse.hw_watchdog_enable || SW_ENABLE;
      win_on = !st_reg.fuse.window_disable;
      code = SLEEPING ? st_reg.fuse.sleep_period_select
                      : st_reg.fuse.run_period_select;
      // exponent is code plus one, kept inside the counter range
      expo = 6'(code) + 6'h01;
      if (code == WDC_CODE_TOP) begin
         expo = 6'(WDC_EXP_TOP);
      end else if (expo > 6'(WDC_EXP_CAP)) begin
         expo = 6'(WDC_EXP_CAP);
      end
      period = WDC_CNT_W'(1) << expo;
      // closed part = period minus open share
      unique case (st_reg.fuse.window_size_select)
         WDC_WS_25: closed_len = period - (period >> 2);
         WDC_WS_375: closed_len = period - (period >> 2) - (period >> 3);
         WDC_WS_50: closed_len = period >> 1;
         default: closed_len = period >> 2;
      endcase
      win_open = !win_on || (st_reg.cnt >= closed_len);
      expired = tick && (st_reg.cnt + WDC_CNT_W'(1) >= period);
      word = {WDC_UNIMPL_VAL, st_reg.fuse};
      // programming can only clear bits, and only once
      wr_fuse = st_reg.fuse & wdc_fuse_t'(WDATA[15:0]);
   end

   // ----------------------------------------------------------------
   // state update
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.wdt_reset = 1'b0;
      if (WR && ADDR == WDC_ADDR_WORD && !st_reg.programmed) begin
         st_next.fuse = wr_fuse;
         st_next.programmed = 1'b1;
      end
      if (!run_on) begin
         st_next.cnt = '0;
      end else if (WDT_CLEAR) begin
         st_next.cnt = '0;
         if (!win_open) st_next.wdt_reset = 1'b1;
      end else if (expired) begin
         st_next.cnt = '0;
         st_next.wdt_reset = 1'b1;
      end else if (tick) begin
         st_next.cnt = st_reg.cnt + WDC_CNT_W'(1);
      end
      st_next.rdata = '0;
      if (RD) begin
         unique case (ADDR)
            WDC_ADDR_WORD: st_next.rdata = word;
            WDC_ADDR_STAT: begin
               st_next.rdata[WDC_ST_RUN] = run_on;
               st_next.rdata[WDC_ST_WIN] = win_on;
               st_next.rdata[WDC_ST_OPEN] = win_open;
               st_next.rdata[WDC_ST_PROG] = st_reg.programmed;
               st_next.rdata[WDC_ST_CLK_LO +: 2] = src;
            end
            WDC_ADDR_CNT: st_next.rdata = st_reg.cnt[23:0];
            default: st_next.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         // fuses are non-volatile: reset keeps them, erased state is all ones
         st_reg.cnt <= '0;
         st_reg.rdata <= '0;
         st_reg.wdt_reset <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign RDATA = st_reg.rdata;
   assign WDT_RESET = st_reg.wdt_reset;
   assign WDT_RUNNING = run_on;
endmodule

//--- tb/watchdog_config_fuses_tb_top.sv
// testbench: register reads, one-shot programming and watchdog timing
`timescale 1ns/1ps
module watchdog_config_fuses_tb_top;
   import wdc_pkg::*;
   logic CORE_CLK = 0, SYS_RST = 1, WR = 0, RD = 0;
   logic SLEEPING = 0, SYS_ON_RC = 0, SW_ENABLE = 0, WDT_CLEAR = 0;
   logic LP_CLK_IN = 0, FRC_CLK_IN = 0, PER_CLK_IN = 0;
   logic [3:0] ADDR = 4'h0;
   logic [23:0] WDATA = 24'h000000;
   logic [23:0] RDATA;
   logic WDT_RESET, WDT_RUNNING;
   int err_total = 0, num_checks = 0, cyc = 0, n = 0;
   wdc_top DUT (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .ADDR(ADDR),
      .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SLEEPING(SLEEPING),
      .SYS_ON_RC(SYS_ON_RC), .SW_ENABLE(SW_ENABLE), .WDT_CLEAR(WDT_CLEAR),
      .LP_CLK_IN(LP_CLK_IN), .FRC_CLK_IN(FRC_CLK_IN),
      .PER_CLK_IN(PER_CLK_IN), .WDT_RESET(WDT_RESET),
      .WDT_RUNNING(WDT_RUNNING));
   always #25 CORE_CLK = ~CORE_CLK;
   // ------------------------------------------------------------
   // source clocks: fast rc 10 cycles, low-power rc 16 cycles
   // ------------------------------------------------------------
   always @(posedge CORE_CLK) begin
      cyc <= cyc + 1;
      FRC_CLK_IN <= (cyc % 10) < 5;
      LP_CLK_IN <= (cyc % 16) < 8;
      PER_CLK_IN <= (cyc % 6) < 3;
   end
   task report_and_stop;
      if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input bit ok, input string m);
      num_checks++;
      if (!ok) begin
         err_total++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   task wr(input logic [3:0] a, input logic [23:0] d);
      @(posedge CORE_CLK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge CORE_CLK);
      WR <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [23:0] m, input logic [23:0] e);
      @(posedge CORE_CLK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge CORE_CLK);
      RD <= 1'b0;
      #1 chk((RDATA & m) === e, "read data");
   endtask
   // counts cycles up to the next reset request
   task wait_rst;
      for (n = 1; n <= 600; n++) begin
         @(posedge CORE_CLK);
         #1;
         if (WDT_RESET === 1'b1) return;
      end
      chk(1'b0, "no watchdog reset");
      report_and_stop;
   endtask
   initial begin
      repeat (4) @(posedge CORE_CLK);
      SYS_RST <= 1'b0;
      rd(WDC_ADDR_WORD, 24'hFFFFFF, 24'hFFFFFF);
      rd(WDC_ADDR_STAT, 24'h00003F, 24'h000005);
      rd(4'hF, 24'hFFFFFF, 24'h000000);
      chk(WDT_RUNNING === 1'b1, "hw enable");
      wr(WDC_ADDR_WORD, 24'h000540);
      wr(WDC_ADDR_WORD, 24'h000000);
      rd(WDC_ADDR_WORD, 24'hFFFFFF, 24'hFF0540);
      chk(WDT_RUNNING === 1'b0, "sw off");
      rd(WDC_ADDR_STAT, 24'h00003F, 24'h00001A);
      @(posedge CORE_CLK) SW_ENABLE <= 1'b1;
      wait_rst;
      wait_rst;
      chk(n == 20, "run period");
      wait_rst;
      @(posedge CORE_CLK) WDT_CLEAR <= 1'b1;
      @(posedge CORE_CLK) WDT_CLEAR <= 1'b0;
      #1 chk(WDT_RESET === 1'b1, "early clear");
      // clear again once the first tick has opened the window
      repeat (12) @(posedge CORE_CLK);
      WDT_CLEAR <= 1'b1;
      @(posedge CORE_CLK) WDT_CLEAR <= 1'b0;
      #1 chk(WDT_RESET === 1'b0, "open clear");
      wait_rst;
      chk(n == 15, "clear restarts period");
      @(posedge CORE_CLK) SYS_ON_RC <= 1'b1;
      repeat (4) @(posedge CORE_CLK);
      rd(WDC_ADDR_STAT, 24'h00003B, 24'h00000B);
      @(posedge CORE_CLK) SYS_ON_RC <= 1'b0;
      SLEEPING <= 1'b1;
      wait_rst;
      wait_rst;
      chk(n == 64, "sleep period");
      // fuses keep their programmed value across a reset
      @(posedge CORE_CLK) SYS_RST <= 1'b1;
      repeat (2) @(posedge CORE_CLK);
      SYS_RST <= 1'b0;
      wr(WDC_ADDR_WORD, 24'h000000);
      rd(WDC_ADDR_WORD, 24'hFFFFFF, 24'hFF0540);
      report_and_stop;
   end
endmodule

//--- tb/wdc_top_sva.sv
// checker: port assertions for the watchdog configuration block
`timescale 1ns/1ps
module wdc_top_sva
   import wdc_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire logic [3:0] ADDR,
   input wire logic RD,
   input wire logic [23:0] RDATA,
   input wire logic SLEEPING,
   input wire logic SYS_ON_RC,
   input wire logic SW_ENABLE,
   input wire logic WDT_RESET,
   input wire logic WDT_RUNNING
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);
   // ------------------------------------------------------------
   // read and watchdog sequences
   // ------------------------------------------------------------
   sequence rd_word;
      RD && ADDR == WDC_ADDR_WORD;
   endsequence
   sequence rd_stat;
      RD && ADDR == WDC_ADDR_STAT;
   endsequence
   sequence rc_held;
      (SLEEPING || SYS_ON_RC) [*3];
   endsequence
   unmapped_read_a: assert property (RD && ADDR > WDC_ADDR_CNT
      |=> RDATA == 24'h000000) else $error("unmapped read not zero");
   rdata_idle_a: assert property (!RD |=> RDATA == 24'h000000)
      else $error("read data outside read slot");
   upper_ones_a: assert property (rd_word
      |=> RDATA[23:16] == WDC_UNIMPL_VAL) else $error("upper bits not ones");
   reset_pulse_a: assert property (WDT_RESET |=> !WDT_RESET)
      else $error("reset request longer than one cycle");
   sw_run_a: assert property (SW_ENABLE |-> WDT_RUNNING)
      else $error("software enable ignored");
   hw_run_a: assert property (rd_word ##1 RDATA[WDC_EN_BIT]
      |-> WDT_RUNNING) else $error("hardware enable ignored");
   off_quiet_a: assert property (!WDT_RUNNING [*3] |-> !WDT_RESET)
      else $error("reset while watchdog off");
   rc_source_a: assert property (rc_held ##0 rd_stat
      |=> RDATA[5:4] == 2'h0) else $error("no fallback to rc clock");
endmodule
bind wdc_top wdc_top_sva u_sva (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
   .ADDR(ADDR), .RD(RD), .RDATA(RDATA), .SLEEPING(SLEEPING),
   .SYS_ON_RC(SYS_ON_RC), .SW_ENABLE(SW_ENABLE), .WDT_RESET(WDT_RESET),
   .WDT_RUNNING(WDT_RUNNING));
